// ==== include/core_regs_params.svh ====
// register offsets, field positions and reset values for the core status/control bank
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH
`define OFS_STATUS     4'h0
`define OFS_CONTROL    4'h4
`define STATUS_RESET   16'h0000
`define CONTROL_RESET  16'h0020
`define B_C            0
`define B_Z            1
`define B_OV           2
`define B_N            3
`define B_RA           4
`define B_PRIO_LO      5
`define B_HC           8
`define B_LOOP_ACT     9
`define B_CLIP_ANY     10
`define B_OVF_ANY      11
`define B_CLIP_B       12
`define B_CLIP_A       13
`define B_OVF_B        14
`define B_OVF_A        15
`define B_IFMODE       0
`define B_RND          1
`define B_FRAME        2
`define B_PRIO_TOP     3
`define B_CLIPW        4
`define B_STCLIP       5
`define B_CLIPEN_B     6
`define B_CLIPEN_A     7
`define B_NEST         8
`define B_EXIT         11
`define B_SIGN         12
`define B_VAR          15
`define UNMAPPED_READ  32'h0000_0000
`endif

// ==== include/core_regs_pkg.sv ====
// types shared by the core status/control bank
package core_regs_pkg;
	typedef enum logic [1:0] {
		mult_signed   = 2'h0,
		mult_unsigned = 2'h1,
		mult_mixed    = 2'h2,
		mult_reserved = 2'h3
	} mult_sign_t;
	typedef enum logic [1:0] {
		bus_idle = 2'b01,
		bus_done = 2'b10
	} bus_state_t;
endpackage

// ==== core/core_status_control_regs.sv ====
// cpu status word and core control register bank with avalon-mm slave
//
// Contract
// - each accumulator clip flag stays set until software clears it
// - clearing the combined clip flag clears both accumulator clip flags
// - combined overflow flag is the or of both accumulator overflows
// - hardware loop active flag follows the loop engine, not writable
// - priority is top bit over three low bits; top bit blocks user interrupts
// - low priority bits read-only while interrupt nesting is off
// - low bits give levels 0-7 or 8-15; 111 also blocks user interrupts
// - repeat loop flag follows the repeat engine
// - signed wrap flag set on signed overflow, cleared otherwise
// - carry from msb, zero on zero result, negative on negative result
// - top priority bit readable and clearable, software write of one ignored
// - top priority bit one when priority is 8 or above
// - latency bit: zero fixed, one variable bounded latency
// - sign field: 00 signed, 01 unsigned, 10 mixed, 11 reserved
// - early exit write one ends loop after iteration; reads zero
// - loop nest level reports active loops in binary, read-only
// - separate clip enables for accumulators a and b
// - store clip enable resets to one, other controls reset to zero
// - clip width: one gives 9.31, zero gives 1.31
// - round mode one biased, zero convergent; multiply one integer
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`include "core_regs_params.svh"
module core_status_control_regs (
	input  wire logic                     core_clk,          // core clock
	input  wire logic                     nrst,              // async reset, active low
	input  wire logic [3:0]               avs_address,       // byte address
	input  wire logic                     avs_read,          // read request
	input  wire logic                     avs_write,         // write request
	input  wire logic [31:0]              avs_writedata,     // write data
	input  wire logic [3:0]               avs_byteenable,    // byte lanes
	output logic      [31:0]              avs_readdata,      // read data
	output logic                          avs_waitrequest,   // stall
	input  wire logic                     alu_update,        // alu result flags valid
	input  wire logic                     alu_carry,         // carry out of msb
	input  wire logic                     alu_half_carry,    // carry out of bit 3 or 7
	input  wire logic                     alu_wrap,          // signed overflow
	input  wire logic                     alu_zero,          // zero result
	input  wire logic                     alu_negative,      // negative result
	input  wire logic                     acc_a_overflow,    // accumulator a overflow
	input  wire logic                     acc_b_overflow,    // accumulator b overflow
	input  wire logic                     acc_a_clip_event,  // accumulator a saturated
	input  wire logic                     acc_b_clip_event,  // accumulator b saturated
	input  wire logic                     hw_loop_active,    // loop engine busy
	input  wire logic                     repeat_loop_active, // repeat engine busy
	input  wire logic [2:0]               loop_nest_level,   // active loop count
	input  wire logic                     frame_active_flag, // stack frame active
	input  wire logic                     interrupt_nesting_off, // nesting disabled
	input  wire logic                     trap_enter,        // hardware raises top bit
	output logic      [3:0]               cpu_priority,      // full priority level
	output logic                          user_irq_block,    // user interrupts blocked
	output logic                          loop_exit_pulse,   // end loop after iteration
	output core_regs_pkg::mult_sign_t     mult_sign_mode,    // multiply sign mode
	output logic                          acc_a_clip_enable, // accumulator a clip on
	output logic                          acc_b_clip_enable, // accumulator b clip on
	output logic                          store_clip_enable, // data store clip on
	output logic                          clip_width_mode,   // 1: 9.31, 0: 1.31
	output logic                          round_mode,        // 1 biased, 0 convergent
	output logic                          mult_int_mode,     // 1 integer, 0 fraction
	output logic                          var_latency        // 1 variable latency
);
	import core_regs_pkg::*;

	bus_state_t   bus_q;
	logic [15:0]  st_q;
	logic [15:0]  ct_q;
	logic         exit_q;
	logic [31:0]  rd_q;

	// decode; one wait cycle so every answer comes from a flop
	wire         req       = avs_read | avs_write;
	wire         accept    = req & (bus_q == bus_idle);
	wire         hit_st    = avs_address == `OFS_STATUS;
	wire         hit_ct    = avs_address == `OFS_CONTROL;
	// writes land on the edge that sees waitrequest low, while address and data still stand
	wire         commit    = req & (bus_q == bus_done);
	wire         wr_lo     = commit & avs_write & avs_byteenable[0];
	wire         wr_hi     = commit & avs_write & avs_byteenable[1];
	wire         wst_lo    = wr_lo & hit_st;
	wire         wst_hi    = wr_hi & hit_st;
	wire         wct_lo    = wr_lo & hit_ct;
	wire         wct_hi    = wr_hi & hit_ct;
	wire [15:0]  wd        = avs_writedata[15:0];

	// clip flags: set wins over software clear; clearing combined clears both
	wire         any_clr   = wst_hi & ~wd[`B_CLIP_ANY];
	wire         clip_a_d  = acc_a_clip_event |
		(st_q[`B_CLIP_A] & ~(any_clr | (wst_hi & ~wd[`B_CLIP_A])));
	wire         clip_b_d  = acc_b_clip_event |
		(st_q[`B_CLIP_B] & ~(any_clr | (wst_hi & ~wd[`B_CLIP_B])));
	wire         ovf_a_d   = acc_a_overflow;
	wire         ovf_b_d   = acc_b_overflow;

	// alu flags: hardware update has priority over a software write
	wire [4:0]   alu_in    = {alu_half_carry, alu_negative, alu_wrap, alu_zero, alu_carry};
	wire [4:0]   alu_sw    = {wd[`B_HC], wd[`B_N], wd[`B_OV], wd[`B_Z], wd[`B_C]};
	wire [4:0]   alu_old   = {st_q[`B_HC], st_q[`B_N], st_q[`B_OV], st_q[`B_Z], st_q[`B_C]};
	wire [4:0]   alu_d;
	assign alu_d = alu_update ? alu_in :
		{wst_hi ? alu_sw[4] : alu_old[4], wst_lo ? alu_sw[3:0] : alu_old[3:0]};

	// low priority bits locked while nesting is off
	wire [2:0]   prio_lo_d = (wst_lo & ~interrupt_nesting_off) ?
		wd[`B_PRIO_LO +: 3] : st_q[`B_PRIO_LO +: 3];

	wire [15:0]  st_d;
	assign st_d = {ovf_a_d, ovf_b_d, clip_a_d, clip_b_d,
		ovf_a_d | ovf_b_d,
		clip_a_d | clip_b_d,
		hw_loop_active,
		alu_d[4], prio_lo_d,
		repeat_loop_active,
		alu_d[3:0]};

	// top priority bit: hardware sets, software only clears
	wire         top_d     = trap_enter | (ct_q[`B_PRIO_TOP] &
		~(wct_lo & ~wd[`B_PRIO_TOP]));

	// writable control fields
	wire [7:0]   ct_lo_w   = wct_lo ? wd[7:0] : ct_q[7:0];
	wire [15:0]  ct_wr     = wct_hi ? wd[15:8] << 8 : {ct_q[15:8], 8'h00};
	wire [15:0]  ct_d;
	assign ct_d = {ct_wr[`B_VAR], 1'b0, ct_wr[`B_SIGN +: 2],
		1'b0, loop_nest_level,
		ct_lo_w[`B_CLIPEN_A], ct_lo_w[`B_CLIPEN_B],
		ct_lo_w[`B_STCLIP], ct_lo_w[`B_CLIPW],
		top_d, frame_active_flag,
		ct_lo_w[`B_RND], ct_lo_w[`B_IFMODE]};

	wire         exit_d    = wct_hi & wd[`B_EXIT] & hw_loop_active;
	wire [31:0]  rd_d      = hit_st ? {16'h0000, st_q} :
		hit_ct ? {16'h0000, ct_q} : `UNMAPPED_READ;
	wire [3:0]   prio_d    = {ct_d[`B_PRIO_TOP], st_d[`B_PRIO_LO +: 3]};

	// bus handshake
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bus_q <= bus_idle;
			rd_q  <= 32'h0000_0000;
		end else begin
			bus_q <= accept ? bus_done : bus_idle;
			rd_q  <= (accept & avs_read) ? rd_d : rd_q;
		end
	end

	// register state; power-on values from the parameter header
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_q   <= `STATUS_RESET;
			ct_q   <= `CONTROL_RESET;
			exit_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			ct_q   <= ct_d;
			exit_q <= exit_d;
		end
	end

	// registered outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cpu_priority   <= 4'h0;
			user_irq_block <= 1'b0;
		end else begin
			cpu_priority   <= prio_d;
			user_irq_block <= prio_d[3] | (prio_d[2:0] == 3'h7);
		end
	end

	assign avs_readdata      = rd_q;
	assign avs_waitrequest   = ~(bus_q == bus_done) & req;
	assign loop_exit_pulse   = exit_q;
	assign mult_sign_mode    = mult_sign_t'(ct_q[`B_SIGN +: 2]);
	assign acc_a_clip_enable = ct_q[`B_CLIPEN_A];
	assign acc_b_clip_enable = ct_q[`B_CLIPEN_B];
	assign store_clip_enable = ct_q[`B_STCLIP];
	assign clip_width_mode   = ct_q[`B_CLIPW];
	assign round_mode        = ct_q[`B_RND];
	assign mult_int_mode     = ct_q[`B_IFMODE];
	assign var_latency       = ct_q[`B_VAR];

	// checks
	a_clip_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
		st_q[`B_CLIP_A] & ~wst_hi |=> st_q[`B_CLIP_A])
		else $error("clip a flag dropped without a clear");
	a_combined_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		any_clr & ~acc_a_clip_event & ~acc_b_clip_event
		|=> ~st_q[`B_CLIP_A] & ~st_q[`B_CLIP_B])
		else $error("combined clear left a clip flag set");
	a_ovf_or: assert property (@(posedge core_clk) disable iff (!nrst)
		st_q[`B_OVF_ANY] == (st_q[`B_OVF_A] | st_q[`B_OVF_B]))
		else $error("combined overflow not or of both");
	a_loop_track: assert property (@(posedge core_clk) disable iff (!nrst)
		##1 st_q[`B_LOOP_ACT] == $past(hw_loop_active))
		else $error("loop active flag wrong");
	a_prio_lock: assert property (@(posedge core_clk) disable iff (!nrst)
		interrupt_nesting_off |=> $stable(st_q[`B_PRIO_LO +: 3]))
		else $error("priority bits changed while locked");
	a_irq_block: assert property (@(posedge core_clk) disable iff (!nrst)
		(ct_q[`B_PRIO_TOP] | (st_q[`B_PRIO_LO +: 3] == 3'h7)) |-> user_irq_block)
		else $error("user interrupts not blocked");
	a_top_noset: assert property (@(posedge core_clk) disable iff (!nrst)
		~ct_q[`B_PRIO_TOP] & ~trap_enter |=> ~ct_q[`B_PRIO_TOP])
		else $error("top priority bit set by software");
	a_exit_reads0: assert property (@(posedge core_clk) disable iff (!nrst)
		~ct_q[`B_EXIT] & ~ct_q[14])
		else $error("early exit bit read nonzero");
	a_alu_flags: assert property (@(posedge core_clk) disable iff (!nrst)
		alu_update |=> st_q[`B_C] == $past(alu_carry) && st_q[`B_OV] == $past(alu_wrap))
		else $error("alu flags not captured");

	// named steps of the early exit handshake and the trap entry
	sequence s_exit_req;
		wct_hi & wd[`B_EXIT] & hw_loop_active;
	endsequence
	sequence s_exit_once;
		loop_exit_pulse ##1 ~loop_exit_pulse;
	endsequence
	sequence s_trap_seen;
		ct_q[`B_PRIO_TOP] & cpu_priority[3];
	endsequence

	// second accumulator keeps its clip flag too
	a_clip_b_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
		st_q[`B_CLIP_B] & ~wst_hi |=> st_q[`B_CLIP_B])
		else $error("clip b flag dropped without a clear");
	// a saturation event always lands, even against a clear
	a_clip_a_set: assert property (@(posedge core_clk) disable iff (!nrst)
		acc_a_clip_event |=> st_q[`B_CLIP_A])
		else $error("clip a event lost");
	// same for accumulator b
	a_clip_b_set: assert property (@(posedge core_clk) disable iff (!nrst)
		acc_b_clip_event |=> st_q[`B_CLIP_B])
		else $error("clip b event lost");
	// combined clip flag follows the two sticky flags
	a_clip_any_or: assert property (@(posedge core_clk) disable iff (!nrst)
		st_q[`B_CLIP_ANY] == (st_q[`B_CLIP_A] | st_q[`B_CLIP_B]))
		else $error("combined clip flag not or of both");
	// overflow a is a one cycle copy of its input
	a_ovf_a_copy: assert property (@(posedge core_clk) disable iff (!nrst)
		acc_a_overflow |=> st_q[`B_OVF_A])
		else $error("overflow a not captured");
	// overflow b likewise
	a_ovf_b_copy: assert property (@(posedge core_clk) disable iff (!nrst)
		acc_b_overflow |=> st_q[`B_OVF_B])
		else $error("overflow b not captured");
	// combined overflow reads zero when neither accumulator overflowed
	a_ovf_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		~acc_a_overflow & ~acc_b_overflow |=> ~st_q[`B_OVF_ANY])
		else $error("combined overflow set without cause");
	// loop flag drops once the loop engine is idle
	a_loop_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		~hw_loop_active |=> ~st_q[`B_LOOP_ACT])
		else $error("loop active flag stuck");
	// repeat flag follows a busy repeat engine
	a_repeat_busy: assert property (@(posedge core_clk) disable iff (!nrst)
		repeat_loop_active |=> st_q[`B_RA])
		else $error("repeat flag missed");
	// and clears when it is idle
	a_repeat_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		~repeat_loop_active |=> ~st_q[`B_RA])
		else $error("repeat flag stuck");
	// wrap flag cleared by an operation without overflow
	a_wrap_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		alu_update & ~alu_wrap |=> ~st_q[`B_OV])
		else $error("wrap flag not cleared");
	// zero result marks the zero flag
	a_zero_set: assert property (@(posedge core_clk) disable iff (!nrst)
		alu_update & alu_zero |=> st_q[`B_Z])
		else $error("zero flag missed");
	// negative result marks the negative flag
	a_neg_set: assert property (@(posedge core_clk) disable iff (!nrst)
		alu_update & alu_negative |=> st_q[`B_N])
		else $error("negative flag missed");
	// half carry set on a carry out of the nibble or byte
	a_hc_set: assert property (@(posedge core_clk) disable iff (!nrst)
		alu_update & alu_half_carry |=> st_q[`B_HC])
		else $error("half carry missed");
	// and cleared otherwise
	a_hc_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		alu_update & ~alu_half_carry |=> ~st_q[`B_HC])
		else $error("half carry not cleared");
	// a trap raises the top bit and the priority together
	a_trap_raise: assert property (@(posedge core_clk) disable iff (!nrst)
		trap_enter |=> s_trap_seen)
		else $error("trap did not raise priority");
	// software clear of the top bit works unless a trap hits
	a_top_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		wct_lo & ~wd[`B_PRIO_TOP] & ~trap_enter |=> ~ct_q[`B_PRIO_TOP])
		else $error("top priority bit not cleared");
	// priority output is the top bit over the low bits
	a_prio_join: assert property (@(posedge core_clk) disable iff (!nrst)
		cpu_priority == {ct_q[`B_PRIO_TOP], st_q[`B_PRIO_LO +: 3]})
		else $error("priority not joined");
	// user interrupts free below level seven with no trap
	a_irq_free: assert property (@(posedge core_clk) disable iff (!nrst)
		~ct_q[`B_PRIO_TOP] & (st_q[`B_PRIO_LO +: 3] != 3'h7) |-> ~user_irq_block)
		else $error("user interrupts blocked needlessly");
	// unlocked low priority bits take the written value
	a_prio_write: assert property (@(posedge core_clk) disable iff (!nrst)
		wst_lo & ~interrupt_nesting_off |=> st_q[`B_PRIO_LO +: 3] == $past(wd[`B_PRIO_LO +: 3]))
		else $error("priority write lost");
	// an exit request with a loop running gives exactly one pulse
	a_exit_fire: assert property (@(posedge core_clk) disable iff (!nrst)
		s_exit_req |=> s_exit_once)
		else $error("early exit pulse wrong");
	// no pulse while no loop runs
	a_exit_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		~hw_loop_active |=> ~loop_exit_pulse)
		else $error("exit pulse without a loop");
	// nesting level mirrors the loop engine one cycle later
	a_nest_track: assert property (@(posedge core_clk) disable iff (!nrst)
		1'b1 |=> ct_q[`B_NEST +: 3] == $past(loop_nest_level))
		else $error("nest level not mirrored");
	// frame flag reads zero with no frame active
	a_frame_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		~frame_active_flag |=> ~ct_q[`B_FRAME])
		else $error("frame flag stuck");
	// clip enables take a low lane write
	a_clip_en_write: assert property (@(posedge core_clk) disable iff (!nrst)
		wct_lo |=> ct_q[`B_CLIPEN_B +: 2] == $past(wd[`B_CLIPEN_B +: 2]))
		else $error("clip enable write lost");
	// sign field takes a high lane write
	a_sign_write: assert property (@(posedge core_clk) disable iff (!nrst)
		wct_hi |=> ct_q[`B_SIGN +: 2] == $past(wd[`B_SIGN +: 2]))
		else $error("sign field write lost");
	// latency bit takes a high lane write
	a_var_write: assert property (@(posedge core_clk) disable iff (!nrst)
		wct_hi |=> ct_q[`B_VAR] == $past(wd[`B_VAR]))
		else $error("latency bit write lost");
	// clip controls only change by a write
	a_ctl_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		~wct_lo |=> $stable(ct_q[`B_CLIPW +: 4]))
		else $error("clip controls changed unasked");
	// rounding and multiply mode only change by a write
	a_rnd_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		~wct_lo |=> $stable(ct_q[`B_IFMODE +: 2]))
		else $error("round or multiply mode changed unasked");
	// a freshly taken request always stalls once
	a_bus_wait: assert property (@(posedge core_clk) disable iff (!nrst)
		accept |-> avs_waitrequest)
		else $error("request not stalled");
	// and is answered on the next edge
	a_bus_answer: assert property (@(posedge core_clk) disable iff (!nrst)
		accept |=> ~avs_waitrequest)
		else $error("request not answered");
endmodule

// ==== tb/core_status_control_regs_test.sv ====
// self-checking bench for the core status and control register bank
`include "core_regs_params.svh"
module core_status_control_regs_test;
	import core_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, alu_update = 0;
	logic alu_carry = 0, alu_half_carry = 0, alu_wrap = 0, alu_zero = 0, alu_negative = 0;
	logic acc_a_overflow = 0, acc_b_overflow = 0, acc_a_clip_event = 0, acc_b_clip_event = 0;
	logic hw_loop_active = 0, repeat_loop_active = 0, frame_active_flag = 0, trap_enter = 0;
	logic interrupt_nesting_off = 0, avs_waitrequest, user_irq_block, loop_exit_pulse;
	logic acc_a_clip_enable, acc_b_clip_enable, store_clip_enable, clip_width_mode;
	logic round_mode, mult_int_mode, var_latency;
	logic [2:0] loop_nest_level = 0;
	logic [3:0] avs_address = 0, avs_byteenable = 4'hf, cpu_priority;
	logic [31:0] avs_writedata = 0, avs_readdata;
	mult_sign_t mult_sign_mode;
	int n_mismatch = 0, compares = 0, n_exit = 0;
	core_status_control_regs dut_u (.core_clk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .alu_update,
		.alu_carry, .alu_half_carry, .alu_wrap, .alu_zero, .alu_negative, .acc_a_overflow,
		.acc_b_overflow, .acc_a_clip_event, .acc_b_clip_event, .hw_loop_active,
		.repeat_loop_active, .loop_nest_level, .frame_active_flag, .interrupt_nesting_off,
		.trap_enter, .cpu_priority, .user_irq_block, .loop_exit_pulse, .mult_sign_mode,
		.acc_a_clip_enable, .acc_b_clip_enable, .store_clip_enable, .clip_width_mode,
		.round_mode, .mult_int_mode, .var_latency);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// pulses counted apart from the bus tasks, since they land mid-access
	always @(posedge core_clk) begin
		if (loop_exit_pulse === 1'b1) n_exit++;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one avalon access; held until waitrequest is sampled low, then a gap edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			final_report();
		end
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		step(2);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	function automatic logic [31:0] ctl_outs();
		return {23'h0, var_latency, mult_sign_mode, acc_a_clip_enable, acc_b_clip_enable,
			store_clip_enable, clip_width_mode, round_mode, mult_int_mode};
	endfunction
	initial begin
		step(5);
		nrst <= 1;
		step(1);
		rd(`OFS_STATUS, 32'h0000_0000);
		rd(`OFS_CONTROL, 32'h0000_0020);
		chk(ctl_outs(), 32'h0000_0008);
		rd(4'h8, `UNMAPPED_READ);
		// exit and top priority bit must not stick from a write of one
		wr(`OFS_CONTROL, 32'h0000_a8fb);
		rd(`OFS_CONTROL, 32'h0000_a0f3);
		chk(ctl_outs(), 32'h0000_01bf);
		for (int i = 0; i < 3; i++) begin
			wr(`OFS_CONTROL, i << 12);
			chk(ctl_outs(), i << 6);
		end
		hw_loop_active <= 1;
		repeat_loop_active <= 1;
		loop_nest_level <= 3'h7;
		frame_active_flag <= 1;
		wr(`OFS_CONTROL, 32'h0000_0800);
		chk(n_exit, 1);
		wr(`OFS_STATUS, 32'h0000_0000);
		rd(`OFS_STATUS, 32'h0000_0210);
		rd(`OFS_CONTROL, 32'h0000_0704);
		{hw_loop_active, repeat_loop_active, loop_nest_level, frame_active_flag} <= 0;
		acc_a_overflow <= 1;
		step(1);
		rd(`OFS_STATUS, 32'h0000_8800);
		{acc_a_overflow, acc_b_overflow} <= 2'b01;
		step(1);
		rd(`OFS_STATUS, 32'h0000_4800);
		acc_b_overflow <= 0;
		step(1);
		rd(`OFS_STATUS, 32'h0000_0000);
		acc_a_clip_event <= 1;
		step(1);
		acc_a_clip_event <= 0;
		rd(`OFS_STATUS, 32'h0000_2400);
		acc_b_clip_event <= 1;
		step(1);
		acc_b_clip_event <= 0;
		rd(`OFS_STATUS, 32'h0000_3400);
		avs_byteenable <= 4'h2;
		wr(`OFS_STATUS, 32'h0000_0000);
		avs_byteenable <= 4'hf;
		rd(`OFS_STATUS, 32'h0000_0000);
		{alu_update, alu_carry, alu_half_carry, alu_negative} <= 4'hf;
		step(1);
		{alu_carry, alu_half_carry, alu_negative, alu_wrap, alu_zero} <= 5'h03;
		step(1);
		alu_update <= 0;
		rd(`OFS_STATUS, 32'h0000_0006);
		wr(`OFS_STATUS, 32'h0000_0109);
		rd(`OFS_STATUS, 32'h0000_0109);
		wr(`OFS_STATUS, 32'h0000_00e0);
		chk({user_irq_block, cpu_priority}, 5'h17);
		wr(`OFS_STATUS, 32'h0000_0040);
		chk({user_irq_block, cpu_priority}, 5'h02);
		interrupt_nesting_off <= 1;
		wr(`OFS_STATUS, 32'h0000_0000);
		rd(`OFS_STATUS, 32'h0000_0040);
		interrupt_nesting_off <= 0;
		trap_enter <= 1;
		step(1);
		trap_enter <= 0;
		step(2);
		rd(`OFS_CONTROL, 32'h0000_0008);
		chk({user_irq_block, cpu_priority}, 5'h1a);
		wr(`OFS_CONTROL, 32'h0000_0000);
		rd(`OFS_CONTROL, 32'h0000_0000);
		final_report();
	end
endmodule
